// *** logic/dmc_map.svh ***
// Offsets, field positions, reset values and timing counts of the command handler
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
`define DMC_CLASS_CMD      2'h0
`define DMC_CLASS_RSP      2'h1
`define DMC_CLASS_RPT      2'h2
`define DMC_CLASS_ERR      2'h3
`define DMC_MAX_LEN        8'h16
`define DMC_PING_MAX       8'h10
`define DMC_AREA_LEN       8'h10
`define DMC_TEMP_SENSORS   32
`define DMC_TEMP_RPT_CODE  8'h82
`define DMC_TEMP_RPT_LEN   8'h04
`define DMC_CLK_HZ         100000000
`define DMC_BAUD           115200
`define DMC_BIT_CYCLES     (`DMC_CLK_HZ / `DMC_BAUD)
`define DMC_ACK_MS         250
`define DMC_ACK_CYCLES     ((`DMC_CLK_HZ / 1000) * `DMC_ACK_MS)
`define DMC_RPT_MS         1000
`define DMC_RPT_CYCLES     ((`DMC_CLK_HZ / 1000) * `DMC_RPT_MS)
`define DMC_PULSE_CYCLES   100000
`define DMC_BLANK_CHAR     8'h20
`define DMC_CHAR_CELLS     80
`define DMC_CRC_INIT       16'hffff
`define DMC_CRC_POLY       16'h8408
`endif

// *** logic/dmc_pkg.sv ***
// Types shared by the command handler
package dmc_pkg;
    typedef enum logic [3:0] {
        DMC_ST_IDLE = 4'h0,
        DMC_ST_LEN  = 4'h1,
        DMC_ST_DATA = 4'h3,
        DMC_ST_CRCL = 4'h2,
        DMC_ST_CRCH = 4'h6,
        DMC_ST_EXEC = 4'h7,
        DMC_ST_SEND = 4'h5,
        DMC_ST_CLR  = 4'h4
    } dmc_state_t;
    typedef enum logic [3:0] {
        DMC_CMD_PING  = 4'h0,
        DMC_CMD_VER   = 4'h1,
        DMC_CMD_WRUA  = 4'h2,
        DMC_CMD_RDUA  = 4'h3,
        DMC_CMD_BOOT  = 4'h4,
        DMC_CMD_RBT   = 4'h5,
        DMC_CMD_CLR   = 4'h6,
        DMC_CMD_OLD   = 4'h7
    } dmc_cmd_t;
endpackage

// *** logic/dmc_fifo.sv ***
// Byte FIFO between the packet builder and the transmitter
`timescale 1ns/1ps
module dmc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } dmc_fifo_t;
    dmc_fifo_t s_q;
    dmc_fifo_t s_d;
    logic      push;
    logic      pop;

    // Honest flags straight from the occupancy count
    assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = s_q.mem[s_q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next state
    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp          = s_q.wp + 1'b1;
        end
        if (pop)
            s_d.rp = s_q.rp + 1'b1;
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end
endmodule

// *** logic/dmc_handler.sv ***
// Packet command interpreter of the serial character display module
// Function
// R1: Type byte: two-bit class, six-bit code
// R2: Packet is type, length, payload, CRC
// R3: Acknowledge every packet within 250 ms
// R4: Link runs 115200 baud, 8N1
// R5: Enabled temperature sensors reported every second
// R6: Each command gets exactly one answer
// R7: Answer code equals command's six-bit code
// R8: Ping code zero, up to sixteen bytes
// R9: Ping reply echoes length and payload
// R10: Version query returns sixteen-byte string
// R11: User area write needs sixteen bytes
// R12: User area read returns stored bytes
// R13: Power-up loads boot configuration
// R14: Store boot state saves display settings
// R15: Reporting and watchdog never saved
// R16: Host enables reporting after initialisation
// R17: Magic 8,18,99 reboots the device
// R18: Magic 12,28,97 pulses host reset
// R19: Magic 3,11,95 switches host power off
// R20: Reboot requests acknowledged with 0x45
// R21: Power control pins keep default mode
// R22: Clear fills memory with spaces, homes cursor
// R23: Code seven is deprecated
// R24: Bad length or magic gets error; lengths above 22 are dropped without an answer
`timescale 1ns/1ps
`include "dmc_map.svh"
module dmc_handler
    import dmc_pkg::*;
#(
    parameter int        ACK_CYCLES   = `DMC_ACK_CYCLES,
    parameter int        RPT_CYCLES   = `DMC_RPT_CYCLES,
    parameter int        PULSE_CYCLES = `DMC_PULSE_CYCLES,
    parameter int        BIT_CYCLES   = `DMC_BIT_CYCLES,
    parameter logic [127:0] VERSION_STR = 128'h44_4d_43_30_30_30_3a_68_31_2e_30_2c_73_31_2e_30
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    input  wire logic        RX_DATA,
    output logic             TX_DATA,
    input  wire logic [31:0] TEMP_REPORT_EN,
    input  wire logic [31:0][15:0] TEMP_VALUE,
    output logic             HOST_RESET,
    output logic             HOST_POWER_OFF,
    output logic             SELF_REBOOT,
    output logic             BOOT_SAVE,
    output logic             ACK_TIMEOUT,
    output logic [6:0]       CURSOR_POS
);
    // VERSION_STR value is arbitrary
    localparam int BW = $clog2(BIT_CYCLES + 1);

    // ---------------------------------------------------------------
    // Whole-module state
    // ---------------------------------------------------------------
    typedef struct packed {
        dmc_state_t                st;
        logic [BW-1:0]             rx_cnt;
        logic [3:0]                rx_bit;
        logic [7:0]                rx_sh;
        logic                      rx_busy;
        logic [7:0]                typ;
        logic [7:0]                len;
        logic [4:0]                idx;
        logic [21:0][7:0]          pay;
        logic [15:0]               crc;
        logic [7:0]                crc_lo;
        logic [7:0]                o_typ;
        logic [7:0]                o_len;
        logic [5:0]                o_idx;
        logic [15:0]               o_crc;
        logic [1:0]                o_src;
        logic [15:0][7:0]          area;
        logic [15:0][7:0]          boot_area;
        logic [6:0]                cursor;
        logic [6:0]                boot_cursor;
        logic [6:0]                clr_idx;
        logic [`DMC_CHAR_CELLS-1:0][7:0] chars;
        logic [31:0]               ack_cnt;
        logic                      ack_to;
        logic [31:0]               rpt_cnt;
        logic [4:0]                rpt_idx;
        logic [31:0]               rpt_pend;
        logic [31:0]               pulse_cnt;
        logic                      host_rst;
        logic                      host_off;
        logic                      reboot;
        logic                      boot_save;
        logic [BW-1:0]             tx_cnt;
        logic [3:0]                tx_bit;
        logic [9:0]                tx_sh;
        logic                      tx_line;
        logic                      boot_done;
    } dmc_st_t;
    dmc_st_t s_q;
    dmc_st_t s_d;

    logic       f_in_valid;
    logic       f_in_ready;
    logic [7:0] f_in_data;
    logic       f_out_valid;
    logic       f_out_ready;
    logic [7:0] f_out_data;

    // One byte step of the reflected CRC-16
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ `DMC_CRC_POLY) : (r >> 1);
        return r;
    endfunction

    // Byte at position n of the packet being sent
    function automatic logic [7:0] tx_byte(input dmc_st_t s, input logic [5:0] n);
        logic [7:0] b;
        logic [5:0] p;
        b = 8'h00;
        p = n - 6'd2;
        if (n == 6'd0)
            b = s.o_typ;
        else if (n == 6'd1)
            b = s.o_len;
        else if (s.o_src == 2'd1)
            b = VERSION_STR[127 - 8*p[3:0] -: 8];
        else if (s.o_src == 2'd2)
            b = s.area[p[3:0]];
        else if (s.o_src == 2'd3)
            b = (p == 6'd0) ? {3'h0, s.rpt_idx} : (p == 6'd1) ? 8'h00
              : (p == 6'd2) ? TEMP_VALUE[s.rpt_idx][7:0] : TEMP_VALUE[s.rpt_idx][15:8];
        else
            b = s.pay[p[4:0]];
        return b;
    endfunction

    assign f_in_data   = (s_q.o_idx == 6'(s_q.o_len) + 6'd2) ? s_q.o_crc[7:0]
                       : (s_q.o_idx == 6'(s_q.o_len) + 6'd3) ? s_q.o_crc[15:8]
                       : tx_byte(s_q, s_q.o_idx);
    assign f_in_valid  = (s_q.st == DMC_ST_SEND);
    assign f_out_ready = (s_q.tx_bit == 4'd0);

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb
    begin
        logic       rx_byte_v;
        logic [7:0] rx_b;
        logic       good;
        rx_byte_v = 1'b0;
        rx_b      = s_q.rx_sh;
        good      = 1'b0;
        s_d       = s_q;
        s_d.reboot    = 1'b0;
        s_d.boot_save = 1'b0;

        // Boot configuration copy at power-up or restart
        if (!s_q.boot_done || s_q.reboot)
        begin
            s_d.area      = s_q.boot_area; // R13
            s_d.cursor    = s_q.boot_cursor;
            s_d.boot_done = 1'b1;
        end

        // Receiver: 8N1 at the bit rate, sampled mid-bit
        if (!s_q.rx_busy)
        begin
            if (!RX_DATA)
            begin
                s_d.rx_busy = 1'b1; // R4
                s_d.rx_cnt  = BW'(BIT_CYCLES / 2);
                s_d.rx_bit  = 4'd0;
            end
        end
        else if (s_q.rx_cnt != '0)
            s_d.rx_cnt = s_q.rx_cnt - 1'b1;
        else
        begin
            s_d.rx_cnt = BW'(BIT_CYCLES - 1);
            s_d.rx_bit = s_q.rx_bit + 1'b1;
            if (s_q.rx_bit == 4'd0 && RX_DATA)
                s_d.rx_busy = 1'b0;
            else if (s_q.rx_bit >= 4'd1 && s_q.rx_bit <= 4'd8)
                s_d.rx_sh = {RX_DATA, s_q.rx_sh[7:1]};
            else if (s_q.rx_bit == 4'd9)
            begin
                s_d.rx_busy = 1'b0;
                rx_byte_v   = RX_DATA;
            end
        end

        // Acknowledge watchdog: flags a packet left waiting too long
        if (s_q.st == DMC_ST_IDLE || s_q.st == DMC_ST_LEN)
            s_d.ack_cnt = '0;
        else if (s_q.ack_cnt == 32'(ACK_CYCLES))
            s_d.ack_to = 1'b1; // R3
        else
            s_d.ack_cnt = s_q.ack_cnt + 1'b1;

        // Once-per-second report tick latches enabled sensors
        if (s_q.rpt_cnt == 32'(RPT_CYCLES - 1))
        begin
            s_d.rpt_cnt  = '0;
            s_d.rpt_pend = s_q.rpt_pend | TEMP_REPORT_EN; // R5
        end
        else
            s_d.rpt_cnt = s_q.rpt_cnt + 1'b1;

        // Host line pulse timer; power-off holds the line until reset
        if (s_q.pulse_cnt != '0)
            s_d.pulse_cnt = s_q.pulse_cnt - 1'b1;
        else
            s_d.host_rst = 1'b0;

        // Packet framing, command decoding and answer generation
        case (s_q.st)
            DMC_ST_IDLE:
            begin
                s_d.crc = `DMC_CRC_INIT;
                s_d.idx = '0;
                if (rx_byte_v && rx_b[7:6] == `DMC_CLASS_CMD) // R1
                begin
                    s_d.typ = rx_b;
                    s_d.crc = crc_step(`DMC_CRC_INIT, rx_b);
                    s_d.st  = DMC_ST_LEN;
                end
                else if (s_q.rpt_pend != '0)
                begin
                    for (int i = 31; i >= 0; i--)
                        if (s_q.rpt_pend[i])
                            s_d.rpt_idx = 5'(i);
                    s_d.o_typ = `DMC_TEMP_RPT_CODE;
                    s_d.o_len = `DMC_TEMP_RPT_LEN;
                    s_d.o_src = 2'd3;
                    s_d.o_idx = '0;
                    s_d.o_crc = `DMC_CRC_INIT;
                    s_d.st    = DMC_ST_SEND;
                end
            end
            DMC_ST_LEN:
            begin
                if (rx_byte_v)
                begin
                    s_d.len = rx_b;
                    s_d.crc = crc_step(s_q.crc, rx_b);
                    // Bad length means lost framing: drop and resync
                    if (rx_b > `DMC_MAX_LEN) // R2
                        s_d.st = DMC_ST_IDLE;
                    else
                        s_d.st = (rx_b == 8'h00) ? DMC_ST_CRCL : DMC_ST_DATA;
                end
            end
            DMC_ST_DATA:
            begin
                if (rx_byte_v)
                begin
                    s_d.pay[s_q.idx] = rx_b;
                    s_d.crc          = crc_step(s_q.crc, rx_b);
                    s_d.idx          = s_q.idx + 1'b1;
                    if (8'(s_q.idx) + 8'd1 == s_q.len)
                        s_d.st = DMC_ST_CRCL;
                end
            end
            DMC_ST_CRCL:
            begin
                if (rx_byte_v)
                begin
                    s_d.crc_lo = rx_b; // R2
                    s_d.st     = DMC_ST_CRCH;
                end
            end
            DMC_ST_CRCH:
            begin
                if (rx_byte_v)
                    s_d.st = ({rx_b, s_q.crc_lo} == ~s_q.crc) ? DMC_ST_EXEC : DMC_ST_IDLE;
            end
            DMC_ST_EXEC:
            begin
                s_d.o_len = 8'h00;
                s_d.o_src = 2'd0;
                s_d.o_idx = '0;
                s_d.o_crc = `DMC_CRC_INIT;
                s_d.st    = DMC_ST_SEND; // R6
                case (s_q.typ[5:0])
                    6'h00:
                    begin
                        good      = (s_q.len <= `DMC_PING_MAX); // R8
                        s_d.o_len = good ? s_q.len : 8'h00; // R9
                    end
                    6'h01:
                    begin
                        good      = (s_q.len == 8'h00);
                        s_d.o_len = good ? `DMC_AREA_LEN : 8'h00; // R10
                        s_d.o_src = 2'd1;
                    end
                    6'h02:
                    begin
                        good = (s_q.len == `DMC_AREA_LEN); // R11
                        if (good)
                            for (int i = 0; i < 16; i++)
                                s_d.area[i] = s_q.pay[i];
                    end
                    6'h03:
                    begin
                        good      = (s_q.len == 8'h00);
                        s_d.o_len = good ? `DMC_AREA_LEN : 8'h00; // R12
                        s_d.o_src = 2'd2;
                    end
                    6'h04:
                    begin
                        good = (s_q.len == 8'h00);
                        // Report enables and watchdog stay outside the saved image
                        if (good)
                        begin
                            s_d.boot_area   = s_q.area; // R14 R15
                            s_d.boot_cursor = s_q.cursor;
                            s_d.boot_save   = 1'b1;
                        end
                    end
                    6'h05:
                    begin
                        good = (s_q.len == 8'h03);
                        if (good && s_q.pay[0] == 8'd8 && s_q.pay[1] == 8'd18
                            && s_q.pay[2] == 8'd99)
                            s_d.reboot = 1'b1; // R17
                        else if (good && s_q.pay[0] == 8'd12 && s_q.pay[1] == 8'd28
                                 && s_q.pay[2] == 8'd97)
                        begin
                            s_d.host_rst  = 1'b1; // R18
                            s_d.pulse_cnt = 32'(PULSE_CYCLES - 1);
                        end
                        else if (good && s_q.pay[0] == 8'd3 && s_q.pay[1] == 8'd11
                                 && s_q.pay[2] == 8'd95)
                            s_d.host_off = 1'b1; // R19
                        else
                            good = 1'b0; // R24
                    end
                    6'h06:
                    begin
                        good = (s_q.len == 8'h00);
                        if (good)
                        begin
                            s_d.cursor  = '0; // R22
                            s_d.clr_idx = '0;
                            s_d.st      = DMC_ST_CLR;
                        end
                    end
                    default:
                        good = 1'b0; // R23
                endcase
                // Class from outcome, code copied from the command
                s_d.o_typ = {good ? `DMC_CLASS_RSP : `DMC_CLASS_ERR, s_q.typ[5:0]}; // R7 R20 R24
            end
            DMC_ST_CLR:
            begin
                s_d.chars[s_q.clr_idx] = `DMC_BLANK_CHAR; // R22
                s_d.clr_idx            = s_q.clr_idx + 1'b1;
                if (s_q.clr_idx == 7'(`DMC_CHAR_CELLS - 1))
                    s_d.st = DMC_ST_SEND;
            end
            DMC_ST_SEND:
            begin
                // Stalls on a full FIFO; the byte is held until accepted
                if (f_in_ready)
                begin
                    s_d.o_idx = s_q.o_idx + 1'b1;
                    if (s_q.o_idx < 6'(s_q.o_len) + 6'd2)
                        s_d.o_crc = crc_step(s_q.o_crc, f_in_data);
                    else if (s_q.o_idx == 6'(s_q.o_len) + 6'd1)
                        s_d.o_crc = ~s_q.o_crc;
                    if (s_q.o_idx == 6'(s_q.o_len) + 6'd3)
                    begin
                        s_d.st = DMC_ST_IDLE;
                        if (s_q.o_src == 2'd3)
                            s_d.rpt_pend[s_q.rpt_idx] = (s_q.rpt_cnt == 32'(RPT_CYCLES - 1))
                                && TEMP_REPORT_EN[s_q.rpt_idx];
                    end
                end
                if (f_in_ready && s_q.o_idx == 6'(s_q.o_len) + 6'd1)
                    s_d.o_crc = ~crc_step(s_q.o_crc, f_in_data);
            end
            default:
                s_d.st = DMC_ST_IDLE;
        endcase

        // Transmitter: shifts start, eight data bits, stop
        if (s_q.tx_bit == 4'd0)
        begin
            s_d.tx_line = 1'b1;
            if (f_out_valid)
            begin
                s_d.tx_sh  = {1'b1, f_out_data, 1'b0}; // R4
                s_d.tx_bit = 4'd11; // Stop bit gets full time
                s_d.tx_cnt = '0;
            end
        end
        else if (s_q.tx_cnt == '0)
        begin
            s_d.tx_line = s_q.tx_sh[0];
            s_d.tx_sh   = {1'b1, s_q.tx_sh[9:1]};
            s_d.tx_bit  = s_q.tx_bit - 1'b1;
            s_d.tx_cnt  = BW'(BIT_CYCLES - 1);
        end
        else
            s_d.tx_cnt = s_q.tx_cnt - 1'b1;
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s_q         <= '0;
            s_q.tx_line <= 1'b1;
            s_q.st      <= DMC_ST_IDLE;
        end
        else
            s_q <= s_d;
    end

    // Outgoing byte queue
    dmc_fifo #(
        .WIDTH (8),
        .DEPTH (16)
    ) u_fifo (
        .clk       (SYS_CLK),
        .rst_n     (RESET_N),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // Outputs straight from flip-flops
    assign TX_DATA        = s_q.tx_line;
    assign HOST_RESET     = s_q.host_rst;
    assign HOST_POWER_OFF = s_q.host_off;
    assign SELF_REBOOT    = s_q.reboot;
    assign BOOT_SAVE      = s_q.boot_save;
    assign ACK_TIMEOUT    = s_q.ack_to;
    assign CURSOR_POS     = s_q.cursor;
endmodule

// *** tb/dmc_host_model.sv ***
// Host-side serial partner: sends command frames, collects answer bytes
`timescale 1ns/1ps
module dmc_host_model #(
    parameter int BIT = 8
) (
    input  wire logic clk,
    input  wire logic line_in,
    output logic      line_out
);
    logic [7:0] rxq[$];
    logic [7:0] b;

    // Line rests at the mark level between frames
    initial line_out = 1'b1;

    // One 8N1 frame, LSB first, moved only on the falling edge
    task automatic send_byte(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(negedge clk);
            line_out = f[i];
            repeat (BIT - 1) @(negedge clk);
        end
    endtask

    // Mid-bit sampling of answers; frames are queued for the bench
    initial
    forever
    begin
        @(negedge line_in);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk);
            b[i] = line_in;
        end
        repeat (BIT) @(posedge clk);
        rxq.push_back(b);
    end
endmodule

// *** tb/dmc_handler_monitor.sv ***
// Port-level checks of the command handler
`timescale 1ns/1ps
module dmc_handler_monitor #(
    parameter int PULSE_CYCLES = 20
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic TX_DATA,
    input wire logic HOST_RESET,
    input wire logic HOST_POWER_OFF,
    input wire logic SELF_REBOOT,
    input wire logic BOOT_SAVE,
    input wire logic ACK_TIMEOUT
);
    logic [31:0] hr_q;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    // Cycles the host reset has been high so far
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            hr_q <= '0;
        else
            hr_q <= HOST_RESET ? hr_q + 32'h1 : '0;
    end

    // Bit time is 8 cycles in this bench, so any level holds 8 cycles
    sequence s_low;
        !TX_DATA [*8];
    endsequence
    sequence s_high;
        TX_DATA [*8];
    endsequence
    property p_low;
        $fell(TX_DATA) |-> s_low;
    endproperty
    property p_high;
        $rose(TX_DATA) |-> s_high;
    endproperty
    property p_idle;
        $rose(RESET_N) |-> TX_DATA;
    endproperty
    property p_hr_len;
        $fell(HOST_RESET) |-> hr_q == 32'(PULSE_CYCLES);
    endproperty
    property p_hr_cap;
        HOST_RESET |-> hr_q < 32'(PULSE_CYCLES);
    endproperty
    property p_reboot;
        SELF_REBOOT |=> !SELF_REBOOT;
    endproperty
    property p_save;
        BOOT_SAVE |=> !BOOT_SAVE;
    endproperty
    property p_poff;
        HOST_POWER_OFF |=> HOST_POWER_OFF;
    endproperty
    property p_ack;
        !ACK_TIMEOUT;
    endproperty
    a_low: assert property (p_low) else $error("short low bit");
    a_high: assert property (p_high) else $error("short high bit");
    a_idle: assert property (p_idle) else $error("line not idle");
    a_hr_len: assert property (p_hr_len) else $error("reset pulse length");
    a_hr_cap: assert property (p_hr_cap) else $error("reset pulse too long");
    a_reboot: assert property (p_reboot) else $error("reboot not a pulse");
    a_save: assert property (p_save) else $error("save not a pulse");
    a_poff: assert property (p_poff) else $error("power off dropped");
    a_ack: assert property (p_ack) else $error("answer overdue");
endmodule

bind dmc_handler dmc_handler_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) u_mon (
    .SYS_CLK(SYS_CLK),
    .RESET_N(RESET_N),
    .TX_DATA(TX_DATA),
    .HOST_RESET(HOST_RESET),
    .HOST_POWER_OFF(HOST_POWER_OFF),
    .SELF_REBOOT(SELF_REBOOT),
    .BOOT_SAVE(BOOT_SAVE),
    .ACK_TIMEOUT(ACK_TIMEOUT)
);

// *** tb/dmc_handler_tb.sv ***
// Self-checking bench of the command handler
`timescale 1ns/1ps
module dmc_handler_tb
    import dmc_pkg::*;
;
    localparam logic [127:0] VER = "UNIT00:h0.1,v0.1"; // Arbitrary
    logic SYS_CLK = 0, RESET_N = 0, RX_DATA;
    logic TX_DATA, HOST_RESET, HOST_POWER_OFF, SELF_REBOOT, BOOT_SAVE, ACK_TIMEOUT;
    logic [6:0] CURSOR_POS;
    logic [31:0] TEMP_REPORT_EN = '0;
    logic [31:0][15:0] TEMP_VALUE = '0;
    logic [7:0] q[$], e[$], ua[$];
    logic [23:0] mg[3] = '{24'h08_12_63, 24'h0c_1c_61, 24'h03_0b_5f};
    int errors = 0, total_checks = 0, n_rb = 0, n_hr = 0, n_sv = 0, k;
    integer seed = 32'hecd2;

    initial forever #5 SYS_CLK = ~SYS_CLK;

    dmc_handler #(.ACK_CYCLES(2000), .RPT_CYCLES(5000), .PULSE_CYCLES(20),
        .BIT_CYCLES(8), .VERSION_STR(VER)) dut (.SYS_CLK(SYS_CLK),
        .RESET_N(RESET_N), .RX_DATA(RX_DATA), .TX_DATA(TX_DATA),
        .TEMP_REPORT_EN(TEMP_REPORT_EN), .TEMP_VALUE(TEMP_VALUE),
        .HOST_RESET(HOST_RESET), .HOST_POWER_OFF(HOST_POWER_OFF),
        .SELF_REBOOT(SELF_REBOOT), .BOOT_SAVE(BOOT_SAVE),
        .ACK_TIMEOUT(ACK_TIMEOUT), .CURSOR_POS(CURSOR_POS));
    dmc_host_model host (.clk(SYS_CLK), .line_in(TX_DATA), .line_out(RX_DATA));

    // Count action pulses; each command may launch at most one
    always @(posedge SYS_CLK)
    begin
        n_rb <= n_rb + SELF_REBOOT;
        n_hr <= n_hr + $rose(HOST_RESET);
        n_sv <= n_sv + BOOT_SAVE;
    end

    // ------
    // Helpers
    // ------
    function automatic logic [15:0] crc(input logic [7:0] p[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (p[i])
        begin
            c ^= p[i];
            repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        return ~c;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    // A corrupted CRC is asked for by a nonzero bad mask
    task automatic cmd(input logic [7:0] t, input logic [7:0] d[$], input logic [15:0] bad = 0);
        logic [7:0] p[$];
        logic [15:0] c;
        p = {t, 8'(d.size()), d};
        c = crc(p) ^ bad;
        foreach (p[i]) host.send_byte(p[i]);
        host.send_byte(c[7:0]);
        host.send_byte(c[15:8]);
    endtask

    // Waits, bounded, for a whole answer, then compares every byte
    task automatic rsp(input logic [7:0] t, input logic [7:0] d[$]);
        logic [7:0] p[$];
        logic [15:0] c;
        int n;
        n = 0;
        while (host.rxq.size() < d.size() + 4 && n < 7000)
        begin
            @(posedge SYS_CLK);
            n++;
        end
        p = {t, 8'(d.size()), d};
        c = crc(p);
        p = {p, c[7:0], c[15:8]};
        foreach (p[i]) chk(host.rxq.pop_front(), p[i]);
        repeat (16) @(posedge SYS_CLK);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------
    // Scenarios
    // ------
    initial
    begin
        repeat (8) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
        RESET_N = 1;
        for (int n = 0; n <= 16; n += 16)
        begin
            q = {};
            repeat (n) q.push_back(8'($random(seed)));
            cmd(8'h00, q);
            rsp(8'h40, q);
        end
        q.push_back(8'h5a);
        cmd(8'h00, q);
        rsp(8'hc0, e);
        q = {};
        for (int i = 15; i >= 0; i--) q.push_back(VER[i*8 +: 8]);
        cmd(8'h01, e);
        rsp(8'h41, q);
        repeat (16) ua.push_back(8'($random(seed)));
        cmd(8'h02, ua);
        rsp(8'h42, e);
        cmd(8'h02, ua[0:14]);
        rsp(8'hc2, e);
        cmd(8'h03, e);
        rsp(8'h43, ua);
        cmd(8'h04, e);
        rsp(8'h44, e);
        chk(16'(n_sv), 16'h1);
        cmd(8'h05, '{8'h08, 8'h12, 8'h62});
        rsp(8'hc5, e);
        foreach (mg[i])
        begin
            cmd(8'h05, '{mg[i][23:16], mg[i][15:8], mg[i][7:0]});
            rsp(8'h45, e);
        end
        chk({n_rb[7:0], n_hr[7:0]}, 16'h0101);
        chk(16'(HOST_POWER_OFF), 16'h1);
        cmd(8'h06, e);
        rsp(8'h46, e);
        chk(16'(CURSOR_POS), 16'h0);
        cmd(8'h07, e);
        rsp(8'hc7, e);
        cmd(8'h00, e, 16'h0001);
        repeat (1500) @(posedge SYS_CLK);
        chk(16'(host.rxq.size()), 16'h0);
        k = $random(seed) & 31;
        @(negedge SYS_CLK);
        TEMP_VALUE[k] = 16'($random(seed));
        TEMP_REPORT_EN[k] = 1'b1;
        rsp(8'h82, '{8'(k), 8'h00, TEMP_VALUE[k][7:0], TEMP_VALUE[k][15:8]});
        end_of_test();
    end

    // Hang guard well beyond the expected run
    initial
    begin
        #600000;
        errors++;
        end_of_test();
    end
endmodule
